/* include/modem_hs_consts.svh */
// Constants for the modem handshake block: register offsets, control and
// status field positions, reset values and the synchroniser pin indices.
// Assumes inclusion by bare name from the include folder.
`ifndef MODEM_HS_CONSTS_SVH
`define MODEM_HS_CONSTS_SVH

// Word address layout: bit 3 set is unmapped, bits 2:1 pick the channel,
// bit 0 picks control (0) or status (1).
`define HS_ADDR_W 4
`define HS_ADDR_UNMAPPED_BIT 3
`define HS_REG_CTRL 1'b0
`define HS_REG_STATUS 1'b1

// Control register fields.
`define HS_CTRL_AUTO_RTS 0
`define HS_CTRL_AUTO_CTS 1
`define HS_CTRL_AUTO_DSR 2
`define HS_CTRL_AUTO_DTR 3
`define HS_CTRL_RTS_ON 4
`define HS_CTRL_DTR_ON 5
`define HS_CTRL_RXCLK_LO 6
`define HS_CTRL_RESET 8'h00

// Receive clock source field values.
`define HS_RXCLK_INTERNAL 2'b00
`define HS_RXCLK_EXTERNAL 2'b01

// Status register fields.
`define HS_STAT_CTS_ON 0
`define HS_STAT_DSR_ON 1
`define HS_STAT_RING 2
`define HS_STAT_TX_PAUSED 3
`define HS_STAT_RTS_ON 4
`define HS_STAT_DTR_ON 5

// Pin sample index inside one synchroniser bank.
`define HS_PIN_CTS 0
`define HS_PIN_DSR 1
`define HS_PIN_RI 2
`define HS_PIN_RXCLK 3
`define HS_PIN_COUNT 4
`define HS_PIN_RESET 4'hf

`endif

/* include/modem_hs_pkg.sv */
// Types used by the modem handshake top.
// Assumes the constants header is on the include path.
`default_nettype none

`include "modem_hs_consts.svh"

package modem_hs_pkg;

   typedef logic [7:0] ctrl_reg_t;

   typedef enum logic [1:0] {
      RXCLK_INTERNAL = `HS_RXCLK_INTERNAL,
      RXCLK_EXTERNAL = `HS_RXCLK_EXTERNAL,
      RXCLK_RSVD_2 = 2'b10,
      RXCLK_RSVD_3 = 2'b11
   } rx_clock_source_t;

endpackage

`default_nettype wire

/* include/pin_sync_if.sv */
// Carrier between the handshake top and one pin synchroniser bank.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if #(parameter int W = 4);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport src (output raw, input synced);
   modport dst (input raw, output synced);
endinterface

`default_nettype wire

/* core/pin_sync.sv */
// Two-stage synchroniser bank for pins from outside the ref_clk domain.
// Assumes the raw levels may change at any time relative to ref_clk.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '1
) (
   // Clock, reset and enable.
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Pin levels in, clean levels out.
   pin_sync_if.dst port
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] clean;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   // The first stage feeds the second stage only.
   always_comb begin
      s_d = s_q;
      if (ce) begin
         s_d.meta = port.raw;
         s_d.clean = s_q.meta;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q <= '{meta: RST_VAL, clean: RST_VAL};
      end else begin
         s_q <= s_d;
      end
   end

   assign port.synced = s_q.clean;

endmodule

`default_nettype wire

/* core/modem_handshake.sv */
// Modem handshake logic for four UART channels, with an Avalon-MM slave.
// Assumes the UART core gives fill levels, thresholds, busy and baud ticks
// on ref_clk; handshake pins and the receive clock are asynchronous.
//
// What this block does
// RULE_01 - Auto RTS drops at upper, returns below lower.
// RULE_02 - Auto CTS: finish character, then hold transmitter.
// RULE_03 - Xon/Xoff characters still go during CTS pause.
// RULE_04 - Auto DSR: finish character, then hold transmitter.
// RULE_05 - Xon/Xoff characters still go during DSR pause.
// RULE_06 - Clock field 01 selects external receive clock.
// RULE_07 - Ring input low means ring present.
// RULE_08 - Auto DTR follows receive fill thresholds.
// RULE_09 - Remote holds CTS/DSR off until ready.
`timescale 1ns/1ps
`default_nettype none

`include "modem_hs_consts.svh"

module modem_handshake
   import modem_hs_pkg::*;
#(
   parameter int CHANNELS = 4,
   parameter int FILL_W = 8
) (
   // Clock, reset and enable.
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ce,
   // Avalon-MM slave.
   input wire logic [`HS_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output var logic [31:0] readdata,
   output var logic waitrequest,
   // Handshake pins, active low, and the receive clock.
   input wire logic [CHANNELS-1:0] cts_n,
   input wire logic [CHANNELS-1:0] dsr_n,
   input wire logic [CHANNELS-1:0] ri_n,
   input wire logic [CHANNELS-1:0] rx_clk_in,
   output var logic [CHANNELS-1:0] rts_n,
   output var logic [CHANNELS-1:0] dtr_n,
   // Receiver side of the UART core.
   input wire logic [CHANNELS-1:0][FILL_W-1:0] rx_fill,
   input wire logic [CHANNELS-1:0][FILL_W-1:0] rx_upper_thr,
   input wire logic [CHANNELS-1:0][FILL_W-1:0] rx_lower_thr,
   input wire logic [CHANNELS-1:0] baud_tick,
   output var logic [CHANNELS-1:0] rx_sample_tick,
   output var logic [CHANNELS-1:0] rx_clk_external,
   // Transmitter side of the UART core, and the ring indication.
   input wire logic [CHANNELS-1:0] tx_busy,
   input wire logic [CHANNELS-1:0] tx_next_is_flow,
   output var logic [CHANNELS-1:0] tx_start_ok,
   output var logic [CHANNELS-1:0] ring_present
);

   localparam int CH_W = $clog2(CHANNELS);

   typedef struct packed {
      // The bus wait level and the line levels are kept as the pins show
      // them, so each output leaves a flop with no gate behind it.
      logic busy;
      logic [31:0] rdata;
      logic [CHANNELS-1:0][7:0] ctrl;
      logic [CHANNELS-1:0] rts_line;
      logic [CHANNELS-1:0] dtr_line;
      logic [CHANNELS-1:0] rxclk_prev;
      logic [CHANNELS-1:0] sample_tick;
      logic [CHANNELS-1:0] ext_clk;
      logic [CHANNELS-1:0] start_ok;
      logic [CHANNELS-1:0] paused;
      logic [CHANNELS-1:0] ring;
   } top_state_t;

   top_state_t s_q;
   top_state_t s_d;

   logic [CHANNELS-1:0][`HS_PIN_COUNT-1:0] pins;

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++) begin : g_chan
         pin_sync_if #(.W(`HS_PIN_COUNT)) sync_port ();

         assign sync_port.raw[`HS_PIN_CTS] = cts_n[g];
         assign sync_port.raw[`HS_PIN_DSR] = dsr_n[g];
         assign sync_port.raw[`HS_PIN_RI] = ri_n[g];
         assign sync_port.raw[`HS_PIN_RXCLK] = rx_clk_in[g];
         assign pins[g] = sync_port.synced;

         pin_sync #(
            .W(`HS_PIN_COUNT),
            .RST_VAL(`HS_PIN_RESET)
         ) u_sync (
            .ref_clk(ref_clk),
            .rst(rst),
            .ce(ce),
            .port(sync_port)
         );
      end
   endgenerate

   always_comb begin
      logic [CH_W-1:0] sel;
      logic [7:0] c;
      logic [31:0] rd;
      logic hold;
      logic rx_edge;
      rx_clock_source_t src;
      sel = address[CH_W:1];
      c = 8'h00;
      rd = 32'h0000_0000;
      hold = 1'b0;
      rx_edge = 1'b0;
      src = RXCLK_INTERNAL;
      s_d = s_q;
      if (ce) begin
         for (int i = 0; i < CHANNELS; i++) begin
            c = s_q.ctrl[i];

            // Threshold flow control drops the line at the upper level and
            // raises it again only once the fill is under the lower level.
            // Between the two the line keeps its state, giving hysteresis.
            if (c[`HS_CTRL_AUTO_RTS]) begin
               if (rx_fill[i] >= rx_upper_thr[i]) begin
                  s_d.rts_line[i] = 1'b1; // [RULE_01]
               end else if (rx_fill[i] < rx_lower_thr[i]) begin
                  s_d.rts_line[i] = 1'b0; // [RULE_01]
               end
            end else begin
               s_d.rts_line[i] = !c[`HS_CTRL_RTS_ON];
            end
            if (c[`HS_CTRL_AUTO_DTR]) begin
               if (rx_fill[i] >= rx_upper_thr[i]) begin
                  s_d.dtr_line[i] = 1'b1; // [RULE_08]
               end else if (rx_fill[i] < rx_lower_thr[i]) begin
                  s_d.dtr_line[i] = 1'b0; // [RULE_08]
               end
            end else begin
               s_d.dtr_line[i] = !c[`HS_CTRL_DTR_ON];
            end

            // Only the start of a new character is gated, so a character
            // already on the wire always completes. Resuming trusts the
            // remote to raise its line only when it can take data again.
            hold = 1'b0;
            if (c[`HS_CTRL_AUTO_CTS] && pins[i][`HS_PIN_CTS]) begin
               hold = 1'b1; // [RULE_02] [RULE_09]
            end
            if (c[`HS_CTRL_AUTO_DSR] && pins[i][`HS_PIN_DSR]) begin
               hold = 1'b1; // [RULE_04] [RULE_09]
            end
            // Flow-control characters bypass the pause.
            s_d.start_ok[i] = !hold || tx_next_is_flow[i]; // [RULE_03] [RULE_05]
            s_d.paused[i] = hold && !tx_busy[i];

            // The external receive clock is oversampled by ref_clk, so it
            // must stay well under half the ref_clk rate.
            src = rx_clock_source_t'(c[`HS_CTRL_RXCLK_LO+1:`HS_CTRL_RXCLK_LO]);
            rx_edge = pins[i][`HS_PIN_RXCLK] && !s_q.rxclk_prev[i];
            s_d.rxclk_prev[i] = pins[i][`HS_PIN_RXCLK];
            if (src == RXCLK_EXTERNAL) begin
               s_d.ext_clk[i] = 1'b1; // [RULE_06]
               s_d.sample_tick[i] = rx_edge; // [RULE_06]
            end else begin
               s_d.ext_clk[i] = 1'b0;
               s_d.sample_tick[i] = baud_tick[i];
            end

            s_d.ring[i] = !pins[i][`HS_PIN_RI]; // [RULE_07]
         end

         // Register read mux.
         if (!address[`HS_ADDR_UNMAPPED_BIT]) begin
            if (address[0] == `HS_REG_CTRL) begin
               rd[7:0] = s_q.ctrl[sel];
            end else begin
               rd[`HS_STAT_CTS_ON] = !pins[sel][`HS_PIN_CTS];
               rd[`HS_STAT_DSR_ON] = !pins[sel][`HS_PIN_DSR];
               rd[`HS_STAT_RING] = s_q.ring[sel];
               rd[`HS_STAT_TX_PAUSED] = s_q.paused[sel];
               rd[`HS_STAT_RTS_ON] = !s_q.rts_line[sel];
               rd[`HS_STAT_DTR_ON] = !s_q.dtr_line[sel];
            end
         end

         // Every access gets exactly one wait state: waitrequest drops in
         // the cycle after the request appears, and the access completes
         // at the edge where the master sees it low.
         if ((read || write) && s_q.busy) begin
            s_d.busy = 1'b0;
            s_d.rdata = rd;
         end else begin
            s_d.busy = 1'b1;
         end
         if (write && !s_q.busy && byteenable[0] &&
             !address[`HS_ADDR_UNMAPPED_BIT] &&
             address[0] == `HS_REG_CTRL) begin
            s_d.ctrl[sel] = writedata[7:0];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         s_q.busy <= 1'b1;
         s_q.rdata <= 32'h0000_0000;
         s_q.ctrl <= {CHANNELS{`HS_CTRL_RESET}};
         s_q.rts_line <= '1;
         s_q.dtr_line <= '1;
         s_q.rxclk_prev <= '1;
         s_q.sample_tick <= '0;
         s_q.ext_clk <= '0;
         s_q.start_ok <= '0;
         s_q.paused <= '0;
         s_q.ring <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign readdata = s_q.rdata;
   assign waitrequest = s_q.busy;
   assign rts_n = s_q.rts_line;
   assign dtr_n = s_q.dtr_line;
   assign rx_sample_tick = s_q.sample_tick;
   assign rx_clk_external = s_q.ext_clk;
   assign tx_start_ok = s_q.start_ok;
   assign ring_present = s_q.ring;

endmodule

`default_nettype wire

/* dv/modem_hs_monitor.sv */
// Checker on the modem_handshake ports, watching channel 0.
// Assumes ce is held high by the bench.
`timescale 1ns/1ps
`default_nettype none
module modem_hs_monitor #(
   parameter int CHANNELS = 4,
   parameter int FILL_W = 8
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst,
   // Bus.
   input wire logic [3:0] address,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   input wire logic waitrequest,
   // Pins and core signals.
   input wire logic [CHANNELS-1:0] cts_n,
   input wire logic [CHANNELS-1:0] dsr_n,
   input wire logic [CHANNELS-1:0] ri_n,
   input wire logic [CHANNELS-1:0] rts_n,
   input wire logic [CHANNELS-1:0] dtr_n,
   input wire logic [CHANNELS-1:0][FILL_W-1:0] rx_fill,
   input wire logic [CHANNELS-1:0][FILL_W-1:0] rx_upper_thr,
   input wire logic [CHANNELS-1:0] baud_tick,
   input wire logic [CHANNELS-1:0] rx_sample_tick,
   input wire logic [CHANNELS-1:0] tx_next_is_flow,
   input wire logic [CHANNELS-1:0] tx_start_ok,
   input wire logic [CHANNELS-1:0] ring_present
);
   // Shadow of the channel 0 control byte; it ignores ce, so it is only
   // sound while ce stays high.
   logic [7:0] c0_q;
   always_ff @(posedge ref_clk) begin
      if (rst)
         c0_q <= 8'h00;
      else if (write && !waitrequest && address == 4'h0 && byteenable[0])
         c0_q <= writedata[7:0];
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   property p_rts_off;
      c0_q[0] && rx_fill[0] >= rx_upper_thr[0] |=> rts_n[0];
   endproperty
   a_rts_off: assert property (p_rts_off) else $error("rts kept");
   property p_dtr_off;
      c0_q[3] && rx_fill[0] >= rx_upper_thr[0] |=> dtr_n[0];
   endproperty
   a_dtr_off: assert property (p_dtr_off) else $error("dtr kept");
   property p_cts_hold;
      (c0_q[1] && cts_n[0] && !tx_next_is_flow[0])[*4] |=> !tx_start_ok[0];
   endproperty
   a_cts_hold: assert property (p_cts_hold) else $error("cts");
   property p_dsr_hold;
      (c0_q[2] && dsr_n[0] && !tx_next_is_flow[0])[*4] |=> !tx_start_ok[0];
   endproperty
   a_dsr_hold: assert property (p_dsr_hold) else $error("dsr");
   property p_flow_go;
      tx_next_is_flow[0] |=> tx_start_ok[0];
   endproperty
   a_flow_go: assert property (p_flow_go) else $error("flow");
   property p_tick_int;
      c0_q[7:6] != 2'b01 && baud_tick[0] |=> rx_sample_tick[0];
   endproperty
   a_tick_int: assert property (p_tick_int) else $error("tick");
   property p_ring;
      (!ri_n[0])[*3] |=> ring_present[0];
   endproperty
   a_ring: assert property (p_ring) else $error("ring");
   property p_ring_off;
      ri_n[0][*3] |=> !ring_present[0];
   endproperty
   a_ring_off: assert property (p_ring_off) else $error("no ring");
endmodule
bind modem_handshake modem_hs_monitor #(
   .CHANNELS(CHANNELS),
   .FILL_W(FILL_W)
) mon_u (.*);
`default_nettype wire

/* dv/remote_modem.sv */
// Remote modem: drives the active-low handshake pins and the link clock.
// Assumes the bench commands readiness; the clock runs only in frames.
`timescale 1ns/1ps
`default_nettype none
module remote_modem (
   // Commands from the bench.
   input wire logic [3:0] cts_ok,
   input wire logic [3:0] dsr_ok,
   input wire logic [3:0] ring,
   input wire logic clk_run,
   // Pins toward the block.
   output var logic [3:0] cts_n,
   output var logic [3:0] dsr_n,
   output var logic [3:0] ri_n,
   output var logic [3:0] rx_clk_in
);
   logic lk = 1'b0;
   // Odd start offset keeps the link clock out of phase with ref_clk.
   initial begin
      #7;
      forever begin
         #160;
         lk = clk_run ? ~lk : 1'b0;
      end
   end
   // Lines stay deasserted until the bench says we can take data.
   assign cts_n = ~cts_ok;
   assign dsr_n = ~dsr_ok;
   assign ri_n = ~ring;
   assign rx_clk_in = {4{lk}};
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Bench for modem_handshake: bus tasks, remote modem, directed tests.
// Assumes the package, design, checker and partner compile first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0;
   logic [3:0] address = 4'h0, cts_ok = 4'hf, dsr_ok = 4'hf, ring = 4'h0;
   logic [31:0] writedata = 32'h0, readdata;
   logic waitrequest, clk_run = 1'b0;
   logic [3:0] cts_n, dsr_n, ri_n, rx_clk_in, rts_n, dtr_n, tick, ext;
   logic [3:0] baud = 4'h0, flow = 4'h0, start_ok, ring_on;
   logic [3:0] be = 4'hf, busy = 4'h0;
   logic [3:0][7:0] fill = '0;
   logic [7:0] q;
   logic [7:0] fv [5] = '{8'h07, 8'h08, 8'h05, 8'h04, 8'h03};
   logic [3:0] ev [5] = '{4'he, 4'hf, 4'hf, 4'hf, 4'he};
   int n_fail = 0, total_checks = 0, n;
   always #20 ref_clk = ~ref_clk;
   modem_handshake dut_u (.ref_clk(ref_clk), .rst(rst), .ce(1'b1),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(be), .readdata(readdata),
      .waitrequest(waitrequest), .cts_n(cts_n), .dsr_n(dsr_n),
      .ri_n(ri_n), .rx_clk_in(rx_clk_in), .rts_n(rts_n), .dtr_n(dtr_n),
      .rx_fill(fill), .rx_upper_thr({4{8'h08}}),
      .rx_lower_thr({4{8'h04}}), .baud_tick(baud),
      .rx_sample_tick(tick), .rx_clk_external(ext), .tx_busy(busy),
      .tx_next_is_flow(flow), .tx_start_ok(start_ok),
      .ring_present(ring_on));
   remote_modem far_u (.cts_ok(cts_ok), .dsr_ok(dsr_ok), .ring(ring),
      .clk_run(clk_run), .cts_n(cts_n), .dsr_n(dsr_n), .ri_n(ri_n),
      .rx_clk_in(rx_clk_in));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
         n_fail++;
      end
   endtask
   // Holds the request until waitrequest is seen low at a rising edge.
   // A hung slave is left to the watchdog.
   task automatic bus(input logic w, input logic [3:0] a,
                      input logic [7:0] d);
      @(posedge ref_clk);
      address <= a;
      write <= w;
      read <= !w;
      writedata <= {24'h0, d};
      do begin
         @(posedge ref_clk);
      end while (waitrequest !== 1'b0);
      q = readdata[7:0];
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task automatic settle;
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100us;
      n_fail++;
      final_report();
   end
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      bus(0, 4'h0, 8'h00);
      chk(q, 8'h00);
      bus(1, 4'h0, 8'h09);
      foreach (fv[i]) begin
         @(posedge ref_clk);
         fill <= {4{fv[i]}};
         settle();
         chk(rts_n, ev[i]);
         chk(dtr_n, ev[i]);
      end
      $display("done: fill levels");
      for (int i = 0; i < 2; i++) begin
         bus(1, 4'h0, 8'h02 << i);
         @(posedge ref_clk);
         if (i == 0)
            cts_ok <= 4'he;
         else
            dsr_ok <= 4'he;
         settle();
         chk(start_ok, 4'he);
         bus(0, 4'h1, 8'h00);
         chk(q & 8'h08, 8'h08);
         busy <= 4'h1;
         bus(0, 4'h1, 8'h00);
         chk(q & 8'h08, 8'h00);
         busy <= 4'h0;
         @(posedge ref_clk);
         flow <= 4'h1;
         settle();
         chk(start_ok, 4'hf);
         @(posedge ref_clk);
         flow <= 4'h0;
         cts_ok <= 4'hf;
         dsr_ok <= 4'hf;
         settle();
         chk(start_ok, 4'hf);
      end
      $display("done: pauses");
      bus(1, 4'h0, 8'h40);
      @(posedge ref_clk);
      clk_run <= 1'b1;
      n = 0;
      repeat (40) begin
         @(posedge ref_clk);
         #1 n += tick[0];
      end
      chk(8'(n >= 4 && n <= 6), 8'h01);
      chk(ext, 4'h1);
      @(posedge ref_clk);
      clk_run <= 1'b0;
      bus(1, 4'h0, 8'h80);
      @(posedge ref_clk);
      baud <= 4'hf;
      @(posedge ref_clk);
      baud <= 4'h0;
      #1 chk(tick, 4'hf);
      $display("done: clocks");
      @(posedge ref_clk);
      ring <= 4'h5;
      settle();
      chk(ring_on, 4'h5);
      bus(0, 4'h1, 8'h00);
      chk(q & 8'h04, 8'h04);
      bus(0, 4'h8, 8'h00);
      chk(q, 8'h00);
      @(posedge ref_clk);
      ring <= 4'h0;
      settle();
      chk(ring_on, 4'h0);
      $display("done: ring");
      bus(1, 4'h0, 8'h30);
      bus(1, 4'h4, 8'h30);
      bus(1, 4'h5, 8'hff);
      bus(1, 4'hc, 8'hff);
      be <= 4'he;
      bus(1, 4'h4, 8'hff);
      be <= 4'hf;
      bus(0, 4'h4, 8'h00);
      chk(q, 8'h30);
      bus(0, 4'h5, 8'h00);
      chk(q & 8'h30, 8'h30);
      chk(rts_n, 4'ha);
      chk(dtr_n, 4'ha);
      $display("done: manual lines");
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      bus(0, 4'h4, 8'h00);
      chk(q, 8'h00);
      chk(rts_n, 4'hf);
      chk(dtr_n, 4'hf);
      $display("done: reset");
      final_report();
   end
endmodule
`default_nettype wire
